/* File: dv/tb.sv */
// Self-checking bench of the line scan trigger sequencer.
// Assumes the AXI4-Lite timing and stream word format of the design.
`timescale 1ns/10ps
`default_nettype none
`include "seq_regs.svh"

module tb;
    logic clk = 1'b0, srst = 1'b1, out_ready = 1'b1;
    logic [7:0] awa = 8'h00, ara = 8'h00;
    logic [31:0] wd = 32'h0, rdata;
    logic awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
    logic awr, wrd, bv, arr, rv, out_valid, line_expose, acq_busy;
    logic [1:0] bresp, rresp;
    logic [17:0] out_data;
    logic [3:0] pulse = 4'h0, level = 4'h0, trig_in;
    logic [17:0] q[$];
    int ex_t[$];
    int n_fail = 0, check_count = 0, cyc = 0;

    always #4 clk = ~clk;

    line_scan_trigger_sequencer line_scan_trigger_sequencer_inst (
        .clk(clk), .srst(srst), .ce(1'b1), .trig_in(trig_in),
        .s_axi_awaddr(awa), .s_axi_awprot(3'h0), .s_axi_awvalid(awv),
        .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_bresp(bresp),
        .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara),
        .s_axi_arprot(3'h0), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
        .s_axi_rready(rr), .out_data(out_data), .out_valid(out_valid),
        .out_ready(out_ready), .line_expose(line_expose),
        .acq_busy(acq_busy));

    trig_src trig_src_inst (
        .clk(clk), .pulse(pulse), .level(level), .trig_in(trig_in));

    // ----------------------------------------
    // Monitor and helpers
    // ----------------------------------------
    // Stream words taken and exposure start cycles
    always @(posedge clk) begin
        if (out_valid && out_ready)
            q.push_back(out_data);
        if (line_expose)
            ex_t.push_back(cyc);
        cyc++;
    end

    task automatic chk(string n, logic [31:0] e, logic [31:0] s);
        check_count++;
        if (s !== e) begin
            $display("[FAIL] %s expected %h seen %h", n, e, s);
            n_fail++;
        end
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic wr(logic [7:0] a, logic [31:0] d);
        int n;
        @(posedge clk);
        awa <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        br <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
            if (awv && awr) awv <= 1'b0;
            if (wv && wrd) wv <= 1'b0;
        end while (!(br && bv) && n < 50);
        br <= 1'b0;
        chk("bvalid", 32'h1, {31'h0, bv});
        chk("bresp", 32'h0, {30'h0, bresp});
    endtask

    task automatic rdc(string nm, logic [7:0] a, logic [31:0] e,
                       logic [1:0] er);
        int n;
        @(posedge clk);
        ara <= a;
        arv <= 1'b1;
        rr <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
            if (arv && arr) arv <= 1'b0;
        end while (!(rr && rv) && n < 50);
        rr <= 1'b0;
        chk("rvalid", 32'h1, {31'h0, rv});
        chk(nm, e, rdata);
        chk("rresp", {30'h0, er}, {30'h0, rresp});
    endtask

    // Next stream word within a bounded wait
    task automatic expw(string n, logic [17:0] e);
        int k;
        k = 0;
        while (q.size() == 0 && k < 600) begin
            @(posedge clk);
            k++;
        end
        chk(n, {14'h0, e}, q.size() > 0 ? {14'h0, q.pop_front()} : ~32'h0);
    endtask

    // One trigger pulse, spaced well above the shortest line time
    task automatic pls(int k);
        @(posedge clk);
        pulse[k] <= 1'b1;
        @(posedge clk);
        pulse[k] <= 1'b0;
        repeat (100) @(posedge clk);
    endtask

    task automatic fresh();
        q.delete();
        ex_t.delete();
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic s_reset();
        rdc("ctrl", `A_CTRL, 32'h0, `RESP_OK);
        rdc("lines", `A_LINES, 32'h3, `RESP_OK);
        rdc("period", `A_PERIOD, 32'h0, `RESP_OK);
        rdc("cmd", `A_CMD, 32'h0, `RESP_OK);
        rdc("unmapped", 8'h40, 32'h0, `RESP_ERR);
        pls(3);
        chk("idle expose", 0, ex_t.size());
        chk("idle busy", 32'h0, {31'h0, acq_busy});
    endtask

    // Single frame free run with the receiver stalled at first
    task automatic s_free();
        fresh();
        out_ready <= 1'b0;
        wr(`A_CTRL, 32'h0);
        wr(`A_CMD, 32'h1);
        repeat (250) @(posedge clk);
        out_ready <= 1'b1;
        expw("line0", 18'h00000);
        expw("line1", 18'h00001);
        expw("line2", 18'h00002);
        expw("end", 18'h20003);
        chk("max rate gap", `LINE_MIN_CYC, ex_t[1] - ex_t[0]);
        repeat (20) @(posedge clk);
        chk("single busy", 32'h0, {31'h0, acq_busy});
        wr(`A_CMD, 32'h1);
        expw("again0", 18'h00000);
        repeat (300) @(posedge clk);
        fresh();
    endtask

    // Continuous paced frames, stop mid-frame, triggers ignored after
    task automatic s_cont();
        fresh();
        wr(`A_PERIOD, 32'h64);
        wr(`A_CTRL, 32'h021);
        wr(`A_CMD, 32'h1);
        expw("c0", 18'h00000);
        expw("c1", 18'h00001);
        expw("c2", 18'h00002);
        expw("cend", 18'h20003);
        expw("next0", 18'h00000);
        wr(`A_CMD, 32'h2);
        expw("partial", 18'h30001);
        chk("period gap", 100, ex_t[1] - ex_t[0]);
        repeat (100) @(posedge clk);
        chk("stop busy", 32'h0, {31'h0, acq_busy});
        fresh();
        pls(2);
        pls(3);
        chk("stop expose", 0, ex_t.size());
    endtask

    // Rising frame trigger on line 2, line trigger on line 3
    task automatic s_edge();
        fresh();
        wr(`A_LINES, 32'h2);
        wr(`A_CTRL, 32'h387);
        wr(`A_CMD, 32'h1);
        pls(3);
        pls(1);
        chk("wait frame", 0, ex_t.size());
        pls(2);
        pls(3);
        pls(3);
        chk("line count", 2, ex_t.size());
        expw("e0", 18'h00000);
        expw("e1", 18'h00001);
        expw("eend", 18'h20002);
        wr(`A_CMD, 32'h2);
        repeat (20) @(posedge clk);
        chk("edge busy", 32'h0, {31'h0, acq_busy});
    endtask

    // Level high frame trigger; closing frame with partial off or on
    task automatic s_lvl(logic part);
        fresh();
        wr(`A_LINES, 32'h3);
        wr(`A_CTRL, part ? 32'h39f : 32'h38f);
        level[2] <= 1'b1;
        wr(`A_CMD, 32'h1);
        repeat (4) pls(3);
        expw("l0", 18'h00000);
        expw("l1", 18'h00001);
        expw("l2", 18'h00002);
        expw("lend", 18'h20003);
        expw("back0", 18'h00000);
        level[2] <= 1'b0;
        repeat (100) @(posedge clk);
        pls(3);
        pls(3);
        if (part) begin
            expw("cut", 18'h30001);
        end else begin
            expw("k1", 18'h00001);
            expw("k2", 18'h00002);
            expw("kend", 18'h20003);
        end
        wr(`A_CMD, 32'h2);
        repeat (20) @(posedge clk);
        chk("lvl busy", 32'h0, {31'h0, acq_busy});
    endtask

    // ----------------------------------------
    // Main sequence and watchdog
    // ----------------------------------------
    initial begin
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        s_reset();
        s_free();
        s_cont();
        s_edge();
        s_lvl(1'b0);
        s_lvl(1'b1);
        conclude();
    end

    initial begin
        repeat (40000) @(posedge clk);
        n_fail++;
        conclude();
    end
endmodule
`default_nettype wire

/* File: dv/trig_src.sv */
// Model of the external trigger sources on the four input lines.
// Assumes the bench strobes pulse for one cycle and holds level.
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------
// Trigger source
// ----------------------------------------
module trig_src (
    input wire logic clk,
    input wire logic [3:0] pulse,
    input wire logic [3:0] level,
    output logic [3:0] trig_in
);
    logic [3:0] c0_ff = 4'h0, c1_ff = 4'h0, c2_ff = 4'h0, c3_ff = 4'h0;

    // Each strobe becomes an 8 cycle high pulse on its line
    always_ff @(posedge clk) begin
        c0_ff <= pulse[0] ? 4'h8 : (c0_ff != 4'h0 ? c0_ff - 4'h1 : 4'h0);
        c1_ff <= pulse[1] ? 4'h8 : (c1_ff != 4'h0 ? c1_ff - 4'h1 : 4'h0);
        c2_ff <= pulse[2] ? 4'h8 : (c2_ff != 4'h0 ? c2_ff - 4'h1 : 4'h0);
        c3_ff <= pulse[3] ? 4'h8 : (c3_ff != 4'h0 ? c3_ff - 4'h1 : 4'h0);
    end

    // Pulses and held levels share the pin; low when idle
    assign trig_in = level | {c3_ff != 4'h0, c2_ff != 4'h0,
                              c1_ff != 4'h0, c0_ff != 4'h0};
endmodule
`default_nettype wire

/* File: hw/line_scan_trigger_sequencer.sv */
// Line scan acquisition sequencer with AXI4-Lite registers.
// Assumes trig_in pins are asynchronous and out_ready is on clk.
`timescale 1ns/10ps
`default_nettype none
`include "seq_regs.svh"

// Behaviour
// RULE1 - All triggers off: acquire lines continuously, no trigger needed.
// RULE2 - Acquisition start is always generated internally.
// RULE3 - Free-run lines are paced by the configured line period.
// RULE4 - Line period disabled: lines run back to back at maximum rate.
// RULE5 - Continuous mode keeps acquiring frames until a stop command.
// RULE6 - Stop during a frame closes it early as a partial frame.
// RULE7 - Frame trigger on: no lines until a frame trigger event occurred.
// RULE8 - Line trigger on: one line per accepted line trigger event.
// RULE9 - External line triggers must stay below maximum line rate.
// RULE10 - Line triggers are discarded while waiting for a frame trigger.
// RULE11 - Each external trigger takes a selectable input line.
// RULE12 - Rising edge activation: each rising transition is one event.
// RULE13 - Level high frame activation: frames follow back to back while high.
// RULE14 - A frame holds lines-per-frame lines, then is closed and sent.
// RULE15 - Partial closing off: falling level still completes the frame.
// RULE16 - Partial closing on: falling level ends the frame at once.
// RULE17 - Single frame mode needs a start command per frame.
// RULE18 - Idle after reset until a start command arrives.
// RULE19 - After stop, return idle and ignore triggers until next start.
module line_scan_trigger_sequencer
    import seq_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic ce,
    input wire logic [3:0] trig_in,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [17:0] out_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic line_expose,
    output logic acq_busy
);

    // ----------------------------------------------------------------
    // Constants and helpers
    // ----------------------------------------------------------------
    localparam logic [23:0] MIN_CYC = 24'(`LINE_MIN_CYC);
    // Exposure plus the one wait-line cycle make the shortest line time
    localparam logic [7:0] EXP_LAST = 8'(`LINE_MIN_CYC - 2);

    // Selects one of the four input lines
    function automatic logic pick(input logic [3:0] v,
                                  input logic [1:0] s);
        pick = v[s];
    endfunction

    // Register hit test
    function automatic logic hit(input logic [7:0] a);
        hit = (a == `A_CTRL) || (a == `A_CMD) || (a == `A_LINES) ||
              (a == `A_PERIOD) || (a == `A_STATUS) ||
              (a == `A_LINECNT);
    endfunction

    // Read value of a register
    function automatic logic [31:0] regval(input seq_state_t s,
                                           input logic [7:0] a);
        regval = 32'h0;
        case (a)
            `A_CTRL: regval = {22'h0, s.ctrl};
            `A_LINES: regval = {16'h0, s.lines};
            `A_PERIOD: regval = {8'h0, s.period};
            `A_STATUS: regval = {s.frames, 9'h0, s.v1, s.stop_pend, s.st};
            `A_LINECNT: regval = {16'h0, s.lcnt};
            default: regval = 32'h0;
        endcase
    endfunction

    // Byte-lane merge of a write
    function automatic logic [31:0] merge(input logic [31:0] o,
                                          input logic [31:0] d,
                                          input logic [3:0] b);
        logic [31:0] m;
        m = {{8{b[3]}}, {8{b[2]}}, {8{b[1]}}, {8{b[0]}}};
        merge = (o & ~m) | (d & m);
    endfunction

    function automatic seq_state_t rst_val();
        seq_state_t s;
        s = '0;
        s.st = S_IDLE;
        s.ctrl = `CTRL_RST;
        s.lines = `LINES_RST;
        s.period = `PERIOD_RST;
        s.awready = 1'b1;
        s.wready = 1'b1;
        s.arready = 1'b1;
        return s;
    endfunction

    seq_state_t r;
    seq_state_t n;
    logic [3:0] rise;
    logic fs_lvl, fs_rise, ls_rise, line_trig, room, pop, push;
    logic wr_go, start, stop, f_on, l_on, lvl, part_en, endnow;
    logic [23:0] per;
    logic [31:0] m;
    seq_word_t w;

    // ----------------------------------------------------------------
    // Next-state logic
    // ----------------------------------------------------------------
    always_comb begin
        n = r;
        n.line_pulse = 1'b0;
        // Two-stage synchronisers, edge detect reads stage two only
        n.sync1 = trig_in;
        n.sync2 = r.sync1;
        n.prev = r.sync2;
        rise = r.sync2 & ~r.prev; // see RULE12
        f_on = r.ctrl[`C_FON];
        l_on = r.ctrl[`C_LON];
        lvl = r.ctrl[`C_FLVL];
        part_en = r.ctrl[`C_PART];
        fs_lvl = pick(r.sync2, r.ctrl[`C_FSRC +: 2]); // see RULE11
        fs_rise = pick(rise, r.ctrl[`C_FSRC +: 2]);
        ls_rise = pick(rise, r.ctrl[`C_LSRC +: 2]);
        // Period floor keeps the line rate legal
        per = (r.ctrl[`C_RATE] && r.period > MIN_CYC) ?
              r.period : MIN_CYC; // see RULE3, see RULE4
        line_trig = l_on ? ls_rise : (r.pcnt >= per); // see RULE8
        room = !r.v1;
        pop = r.v0 && out_ready;
        push = 1'b0;
        w = '0;

        // AXI write channels, taken in either order
        if (s_axi_awvalid && r.awready) begin
            n.aw_ok = 1'b1;
            n.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && r.wready) begin
            n.w_ok = 1'b1;
            n.wdata = s_axi_wdata;
            n.wstrb = s_axi_wstrb;
        end
        n.bvalid = r.bvalid && !s_axi_bready;
        wr_go = r.aw_ok && r.w_ok && !r.bvalid;
        m = merge(regval(r, r.awaddr), r.wdata, r.wstrb);
        start = 1'b0;
        stop = 1'b0;
        if (wr_go) begin
            n.aw_ok = 1'b0;
            n.w_ok = 1'b0;
            n.bvalid = 1'b1;
            n.bresp = hit(r.awaddr) ? `RESP_OK : `RESP_ERR;
            case (r.awaddr)
                `A_CTRL: n.ctrl = m[9:0];
                `A_LINES: n.lines = m[15:0];
                `A_PERIOD: n.period = m[23:0];
                `A_CMD: begin
                    start = m[`K_START];
                    stop = m[`K_STOP];
                end
                default: ;
            endcase
        end
        n.awready = !n.aw_ok && !n.bvalid;
        n.wready = !n.w_ok && !n.bvalid;

        // AXI read channel
        if (s_axi_arvalid && r.arready) begin
            n.arready = 1'b0;
            n.rvalid = 1'b1;
            n.rdata = regval(r, s_axi_araddr);
            n.rresp = hit(s_axi_araddr) ? `RESP_OK : `RESP_ERR;
        end else if (r.rvalid && s_axi_rready) begin
            n.rvalid = 1'b0;
            n.arready = 1'b1;
        end

        // Stop is remembered until the next start command clears it
        n.stop_pend = r.stop_pend || (stop && r.st != S_IDLE);
        // Level frame input dropping inside a frame
        if (f_on && lvl && !fs_lvl &&
            (r.st == S_WLINE || r.st == S_EXP)) begin
            n.fs_fell = 1'b1;
        end
        n.pcnt = r.pcnt + {23'h0, r.pcnt != 24'hffffff};
        endnow = r.stop_pend || (r.fs_fell && part_en);

        // Sequencer
        unique case (r.st)
            S_IDLE: begin
                if (start) begin // see RULE18
                    n.st = f_on ? S_WFRM : S_WLINE; // see RULE2
                    n.lcnt = 16'h0;
                    n.stop_pend = 1'b0;
                    n.fs_fell = 1'b0;
                end
            end
            S_WFRM: begin
                // Line triggers are not looked at here, see RULE10
                if (r.stop_pend) begin
                    n.st = S_IDLE; // see RULE19
                end else if (lvl ? fs_lvl : fs_rise) begin
                    n.st = S_WLINE; // see RULE7, see RULE13
                    n.lcnt = 16'h0;
                    n.fs_fell = 1'b0;
                end
            end
            S_WLINE: begin
                if (endnow) begin
                    n.part = 1'b1;
                    // Cut frame with lines is sent, see RULE6, see RULE16
                    n.st = (r.lcnt != 16'h0) ? S_CLOSE :
                           (r.stop_pend ? S_IDLE : S_WFRM);
                end else if (line_trig && room) begin
                    n.st = S_EXP; // see RULE1, see RULE8
                    n.ecnt = 8'h0;
                    n.pcnt = 24'h1; // Start cycle counts toward the period
                    n.line_pulse = 1'b1;
                end
            end
            S_EXP: begin
                if (r.ecnt != EXP_LAST) begin
                    n.ecnt = r.ecnt + 8'h1;
                end else if (room) begin
                    push = 1'b1;
                    w = {2'b00, r.lcnt};
                    n.lcnt = r.lcnt + 16'h1;
                    n.part = (r.lcnt + 16'h1) < r.lines;
                    // Falling level without partial closing completes
                    n.st = (!n.part || endnow) ? S_CLOSE :
                           S_WLINE; // see RULE14, see RULE15
                end
            end
            S_CLOSE: begin
                if (room) begin
                    push = 1'b1;
                    w = {1'b1, r.part, r.lcnt};
                    n.frames = r.frames + 16'h1;
                    n.lcnt = 16'h0;
                    n.fs_fell = 1'b0;
                    n.st = (r.stop_pend || !r.ctrl[`C_CONT]) ? S_IDLE :
                           (f_on ? S_WFRM : S_WLINE); // see RULE5, see RULE19
                end
            end
        endcase

        // Two-entry output buffer
        case ({push, pop})
            2'b10: begin
                if (!r.v0) begin
                    n.q0 = w;
                    n.v0 = 1'b1;
                end else begin
                    n.q1 = w;
                    n.v1 = 1'b1;
                end
            end
            2'b01: begin
                n.q0 = r.q1;
                n.v0 = r.v1;
                n.v1 = 1'b0;
            end
            2'b11: begin
                n.q0 = r.v1 ? r.q1 : w;
                n.q1 = w;
            end
            default: ;
        endcase
        n.busy = (n.st != S_IDLE);
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (srst) begin
            r <= rst_val();
        end else if (ce) begin
            r <= n;
        end
    end

    // Outputs straight from the state register
    assign s_axi_awready = r.awready;
    assign s_axi_wready = r.wready;
    assign s_axi_bvalid = r.bvalid;
    assign s_axi_bresp = r.bresp;
    assign s_axi_arready = r.arready;
    assign s_axi_rvalid = r.rvalid;
    assign s_axi_rdata = r.rdata;
    assign s_axi_rresp = r.rresp;
    assign out_data = r.q0;
    assign out_valid = r.v0;
    assign line_expose = r.line_pulse;
    assign acq_busy = r.busy;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst || !ce);

    sequence s_fall_wait;
        r.st == S_WLINE && r.fs_fell && part_en && r.lcnt != 16'h0;
    endsequence
    sequence s_stop_wait;
        r.st == S_WLINE && r.stop_pend && r.lcnt != 16'h0;
    endsequence

    idle_hold_a: assert property ( // see RULE18
        r.st == S_IDLE && !start |=> r.st == S_IDLE)
        else $error("left idle without start");
    free_pace_a: assert property ( // see RULE3
        r.st == S_WLINE && n.st == S_EXP && !l_on
        |-> r.pcnt >= per)
        else $error("free-run line too early");
    max_rate_a: assert property ( // see RULE4
        r.st == S_WLINE && !l_on && !r.ctrl[`C_RATE] && !endnow &&
        room && r.pcnt >= MIN_CYC |=> line_expose)
        else $error("free-run line not started at max rate");
    ext_line_a: assert property ( // see RULE8
        r.st == S_WLINE && l_on && ls_rise && room && !endnow
        |=> line_expose && r.st == S_EXP)
        else $error("line trigger not honoured");
    wait_ign_a: assert property ( // see RULE10
        r.st == S_WFRM |=> !line_expose)
        else $error("line taken while waiting for frame");
    frame_gate_a: assert property ( // see RULE7
        r.st == S_WFRM && !lvl && !fs_rise && !r.stop_pend
        |=> r.st == S_WFRM)
        else $error("frame began without trigger");
    frame_len_a: assert property ( // see RULE14
        r.st == S_EXP && push && r.lcnt + 16'h1 >= r.lines
        |=> r.st == S_CLOSE ##1 (r.st != S_CLOSE || !$past(room)))
        else $error("frame not closed at line count");
    fall_close_a: assert property ( // see RULE16
        s_fall_wait |=> r.st == S_CLOSE && r.part)
        else $error("partial closing frame not ended");
    stop_close_a: assert property ( // see RULE6
        s_stop_wait |=> r.st == S_CLOSE && r.part)
        else $error("stop did not close partial frame");
    stop_idle_a: assert property ( // see RULE19
        r.st == S_WFRM && r.stop_pend
        |=> r.st == S_IDLE ##1 !line_expose)
        else $error("stop not returning idle");

endmodule
`default_nettype wire

/* File: hw/seq_pkg.sv */
// Types of the line scan trigger sequencer.
// Assumes seq_regs.svh for numeric constants.
package seq_pkg;

    typedef enum logic [4:0] {
        S_IDLE  = 5'b00001,
        S_WFRM  = 5'b00010,
        S_WLINE = 5'b00100,
        S_EXP   = 5'b01000,
        S_CLOSE = 5'b10000
    } seq_st_t;

    // Output word: [17] end of frame, [16] partial, [15:0] index/count
    typedef logic [17:0] seq_word_t;

    typedef struct packed {
        seq_st_t st;
        logic busy;
        logic [9:0] ctrl;
        logic [15:0] lines;
        logic [23:0] period;
        logic awready;
        logic aw_ok;
        logic [7:0] awaddr;
        logic wready;
        logic w_ok;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [3:0] sync1;
        logic [3:0] sync2;
        logic [3:0] prev;
        logic stop_pend;
        logic fs_fell;
        logic part;
        logic [15:0] lcnt;
        logic [23:0] pcnt;
        logic [7:0] ecnt;
        logic [15:0] frames;
        logic line_pulse;
        seq_word_t q0;
        seq_word_t q1;
        logic v0;
        logic v1;
    } seq_state_t;

endpackage

/* File: hw/seq_regs.svh */
// Register offsets, field positions, reset values and timing counts
// of the line scan trigger sequencer. Definitions only.
`ifndef SEQ_REGS_SVH
`define SEQ_REGS_SVH

// Byte offsets on the AXI4-Lite bus
`define A_CTRL    8'h00
`define A_CMD     8'h04
`define A_LINES   8'h08
`define A_PERIOD  8'h0c
`define A_STATUS  8'h10
`define A_LINECNT 8'h14

// Control field positions
`define C_CONT 0
`define C_FON  1
`define C_LON  2
`define C_FLVL 3
`define C_PART 4
`define C_RATE 5
`define C_FSRC 6
`define C_LSRC 8

// Command bits
`define K_START 0
`define K_STOP  1

// Reset values
`define CTRL_RST   10'h000
`define LINES_RST  16'h0003
`define PERIOD_RST 24'h000000

// Bus responses
`define RESP_OK  2'b00
`define RESP_ERR 2'b10

// Shortest line time, ns, and its cycle count at the 8 ns clock
`define CLK_NS       8
`define LINE_MIN_NS  512
`define LINE_MIN_CYC ((`LINE_MIN_NS + `CLK_NS - 1) / `CLK_NS)

`endif
